/* File: rtl/mioc_pkg.sv */
// Package with the constants of the motion I/O point configuration block.
package mioc_pkg;
  // Number of configurable points and width of a type code.
  localparam int NUM_POINTS = 4;
  localparam int TYPE_W     = 5;
  // Register word offsets on the plain register port.
  localparam logic [3:0] OFF_CFG0   = 4'h0;
  localparam logic [3:0] OFF_GPO    = 4'h4;
  localparam logic [3:0] OFF_INSTAT = 4'h5;
  localparam logic [3:0] OFF_FLAGS  = 4'h6;
  // Field positions.
  localparam int CFG_TYPE_LSB  = 0;
  localparam int CFG_ACT_BIT   = 8;
  localparam int INSTAT_RAW_LSB = 4;
  localparam int FLG_LAG_BIT   = 0;
  localparam int FLG_PAUSE_BIT = 1;
  localparam int FLG_PBLK_BIT  = 2;
  localparam int FLG_MBLK_BIT  = 3;
  // Reset values.
  localparam logic [4:0] RST_TYPE = 5'h00;
  localparam logic       RST_ACT  = 1'b0;
  localparam logic [3:0] RST_GPO  = 4'h0;
  // Point type codes.
  localparam logic [4:0] T_GPIN  = 5'h00;
  localparam logic [4:0] T_HOME  = 5'h01;
  localparam logic [4:0] T_LIMP  = 5'h02;
  localparam logic [4:0] T_LIMM  = 5'h03;
  localparam logic [4:0] T_START = 5'h04;
  localparam logic [4:0] T_SSTOP = 5'h05;
  localparam logic [4:0] T_PAUSE = 5'h06;
  localparam logic [4:0] T_JOGP  = 5'h07;
  localparam logic [4:0] T_JOGM  = 5'h08;
  localparam logic [4:0] T_GPOUT = 5'h10;
  localparam logic [4:0] T_MOVE  = 5'h11;
  localparam logic [4:0] T_FAULT = 5'h12;
  localparam logic [4:0] T_STALL = 5'h13;
  localparam logic [4:0] T_VELOCITY_CHANGING_OUTPUT  = 5'h14;
  // Motion error codes and program start address.
  localparam logic [7:0]  ERR_LIMP   = 8'h53;
  localparam logic [7:0]  ERR_LIMM   = 8'h54;
  localparam logic [15:0] START_ADDR = 16'h0001;
endpackage : mioc_pkg

/* File: rtl/mioc_sync.sv */
// Two flip-flop synchroniser for pin levels.
`timescale 1ns/1ps
module mioc_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // First and second stage; only the second stage is visible outside.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mioc_sync_st_t;

  mioc_sync_st_t st_ff, nxt_st;

  // The first stage feeds nothing but the second stage.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule : mioc_sync

/* File: rtl/mioc_point.sv */
// One I/O point: polarity, edge detection and output drive.
`timescale 1ns/1ps
module mioc_point
  import mioc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              pin_sync,
  input  wire logic [TYPE_W-1:0] cfg_type,
  input  wire logic              cfg_act,
  input  wire logic              gpo_val,
  input  wire logic              motion_active_flag,
  input  wire logic              error_indicator_flag,
  input  wire logic              lag_fault_flag,
  input  wire logic              velocity_changing_flag,
  output logic                   true_lvl,
  output logic                   rise,
  output logic                   pin_out,
  output logic                   pin_oe
);
  // Previous true level and registered pin drive.
  typedef struct packed {
    logic prev;
    logic out;
    logic oe;
  } mioc_point_st_t;

  mioc_point_st_t st_ff, nxt_st;
  logic           asserted;  // Output function is asserted.

  // Polarity: active 1 means high is true, active 0 means low is true.
  assign true_lvl = cfg_act ? pin_sync : ~pin_sync;
  // Edge functions (limit stop, start, soft stop, pause) act on the false to true change only.
  assign rise = true_lvl & ~st_ff.prev;

  // Output selection; input types leave the pin undriven (sinking input).
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = true_lvl;
    asserted    = 1'b0;
    nxt_st.oe   = 1'b1;
    case (cfg_type)
      T_GPOUT: asserted = gpo_val;
      T_MOVE:  asserted = motion_active_flag;
      T_FAULT: asserted = error_indicator_flag;
      T_STALL: asserted = lag_fault_flag;
      T_VELOCITY_CHANGING_OUTPUT:  asserted = velocity_changing_flag;
      default: nxt_st.oe = 1'b0;
    endcase
    // Drive the true level when asserted, the opposite level otherwise.
    nxt_st.out = nxt_st.oe & (asserted ? cfg_act : ~cfg_act);
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.out;
  assign pin_oe  = st_ff.oe;

  // A moving output follows the motion flag with the chosen polarity.
  property p_move_out;
    @(posedge clk) disable iff (!rst_n)
    (cfg_type == T_MOVE) |=> pin_oe && (pin_out == ($past(motion_active_flag) ? $past(cfg_act) : !$past(cfg_act)));
  endproperty
  a_move_out: assert property (p_move_out) else $error("Moving output level wrong.");

  // A stall output follows the lag fault flag with the chosen polarity.
  property p_stall_out;
    @(posedge clk) disable iff (!rst_n)
    (cfg_type == T_STALL) ##1 (cfg_type == T_STALL) |-> pin_out == ($past(lag_fault_flag) ^ !$past(cfg_act));
  endproperty
  a_stall_out: assert property (p_stall_out) else $error("Stall output level wrong.");

  // Input types never drive the pin.
  property p_in_no_drive;
    @(posedge clk) disable iff (!rst_n)
    (cfg_type < T_GPOUT) |=> !pin_oe;
  endproperty
  a_in_no_drive: assert property (p_in_no_drive) else $error("Input point drives its pin.");
endmodule : mioc_point

/* File: rtl/mioc_top.sv */
// Top of the motion I/O point configuration block with register port.
// Functional notes
// - Four points, each input, output or function.
// - Setup holds type code and polarity per point.
// - Polarity 0 true low, 1 true high.
// - Reset: type 0 input, true when low.
// - Type 2 plus limit: stop, error 83.
// - Type 3 minus limit: stop, error 84.
// - Type 4 starts program at address 1.
// - Type 5 soft stop, program and motion.
// - Type 6 pauses, next activation resumes.
// - Types 7 and 8 jog plus and minus.
// - Type 17 follows the motion flag.
// - Type 18 follows the error flag.
// - Type 19 follows the lag fault flag.
// - Type 20 follows velocity changing flag.
// - Lag fault sticky until software clears.
`timescale 1ns/1ps
module mioc_top
  import mioc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            bus_addr,
  input  wire logic [31:0]           bus_wdata,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  output logic      [31:0]           bus_rdata,
  input  wire logic [NUM_POINTS-1:0] io_pin_in,
  output logic      [NUM_POINTS-1:0] io_pin_out,
  output logic      [NUM_POINTS-1:0] io_pin_oe,
  input  wire logic                  motion_active_flag,
  input  wire logic                  error_indicator_flag,
  input  wire logic                  velocity_changing_flag,
  input  wire logic                  stall_detect,
  output logic                       lag_fault_flag,
  output logic                       home_input,
  output logic                       plus_limit_stop,
  output logic                       minus_limit_stop,
  output logic                       plus_move_block,
  output logic                       minus_move_block,
  output logic                       motion_error_valid,
  output logic      [7:0]            motion_error_code,
  output logic                       program_start,
  output logic      [15:0]           program_start_addr,
  output logic                       soft_stop,
  output logic                       pause_request,
  output logic                       resume_request,
  output logic                       paused,
  output logic                       jog_plus,
  output logic                       jog_minus
);
  // Whole state of the block in one record.
  typedef struct packed {
    logic [NUM_POINTS-1:0][TYPE_W-1:0] cfg_type;  // Type code per point.
    logic [NUM_POINTS-1:0]             cfg_act;   // Polarity per point.
    logic [NUM_POINTS-1:0]             gpo;       // General output values.
    logic                              lag;       // Sticky lag fault.
    logic                              paused;    // Program paused.
    logic                              home;      // Home input level.
    logic                              pblk;      // Plus moves blocked.
    logic                              mblk;      // Minus moves blocked.
    logic                              plim;      // Plus limit hit pulse.
    logic                              mlim;      // Minus limit hit pulse.
    logic                              err_vld;   // Error recorded pulse.
    logic [7:0]                        err_code;  // Last motion error.
    logic                              start;     // Program start pulse.
    logic [15:0]                       start_addr; // Start address.
    logic                              sstop;     // Soft stop pulse.
    logic                              pause_req; // Pause pulse.
    logic                              resume_req; // Resume pulse.
    logic                              jogp;      // Jog plus level.
    logic                              jogm;      // Jog minus level.
    logic [31:0]                       rdata;     // Read data.
  } mioc_st_t;

  mioc_st_t              st_ff, nxt_st;
  logic [NUM_POINTS-1:0] pin_sync;  // Synchronised pin levels.
  logic [NUM_POINTS-1:0] true_lvl;  // Levels after polarity.
  logic [NUM_POINTS-1:0] rise;      // False to true changes.

  // Pins come from outside the clock domain, so two flops first.
  mioc_sync #(
    .W (NUM_POINTS)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (io_pin_in),
    .q     (pin_sync)
  );

  // One instance per point handles polarity, edges and output drive.
  for (genvar i = 0; i < NUM_POINTS; i++) begin : g_pt
    mioc_point u_pt (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .pin_sync               (pin_sync[i]),
      .cfg_type               (st_ff.cfg_type[i]),
      .cfg_act                (st_ff.cfg_act[i]),
      .gpo_val                (st_ff.gpo[i]),
      .motion_active_flag     (motion_active_flag),
      .error_indicator_flag   (error_indicator_flag),
      .lag_fault_flag         (st_ff.lag),
      .velocity_changing_flag (velocity_changing_flag),
      .true_lvl               (true_lvl[i]),
      .rise                   (rise[i]),
      .pin_out                (io_pin_out[i]),
      .pin_oe                 (io_pin_oe[i])
    );
  end

  // Per-function levels and edges, ORed over all points of that type.
  logic home_lvl, plim_lvl, jogp_lvl, jogm_lvl, mlim_lvl;
  logic plim_rise, mlim_rise, start_rise, sstop_rise, pause_rise;

  // Collect the dedicated input functions from every point.
  always_comb begin
    home_lvl   = 1'b0;
    plim_lvl   = 1'b0;
    mlim_lvl   = 1'b0;
    jogp_lvl   = 1'b0;
    jogm_lvl   = 1'b0;
    plim_rise  = 1'b0;
    mlim_rise  = 1'b0;
    start_rise = 1'b0;
    sstop_rise = 1'b0;
    pause_rise = 1'b0;
    for (int i = 0; i < NUM_POINTS; i++) begin
      case (st_ff.cfg_type[i])
        T_HOME:  home_lvl = home_lvl | true_lvl[i];
        T_LIMP: begin
          plim_lvl  = plim_lvl | true_lvl[i];
          plim_rise = plim_rise | rise[i];
        end
        T_LIMM: begin
          mlim_lvl  = mlim_lvl | true_lvl[i];
          mlim_rise = mlim_rise | rise[i];
        end
        T_START: start_rise = start_rise | rise[i];
        T_SSTOP: sstop_rise = sstop_rise | rise[i];
        T_PAUSE: pause_rise = pause_rise | rise[i];
        T_JOGP:  jogp_lvl = jogp_lvl | true_lvl[i];
        T_JOGM:  jogm_lvl = jogm_lvl | true_lvl[i];
        default: ;
      endcase
    end
  end

  // Next-state logic: register port, sticky flag and event outputs.
  always_comb begin
    nxt_st            = st_ff;
    nxt_st.plim       = 1'b0;
    nxt_st.mlim       = 1'b0;
    nxt_st.err_vld    = 1'b0;
    nxt_st.start      = 1'b0;
    nxt_st.sstop      = 1'b0;
    nxt_st.pause_req  = 1'b0;
    nxt_st.resume_req = 1'b0;
    nxt_st.rdata      = 32'h0000_0000;
    // Writes: setup per point takes the type code and the polarity.
    if (bus_wr) begin
      if (bus_addr < OFF_GPO) begin
        nxt_st.cfg_type[bus_addr[1:0]] = bus_wdata[CFG_TYPE_LSB +: TYPE_W];
        nxt_st.cfg_act[bus_addr[1:0]]  = bus_wdata[CFG_ACT_BIT];
      end else if (bus_addr == OFF_GPO) begin
        nxt_st.gpo = bus_wdata[NUM_POINTS-1:0];
      end else if (bus_addr == OFF_FLAGS && !bus_wdata[FLG_LAG_BIT]) begin
        nxt_st.lag = 1'b0;
      end
    end
    // A stall in the cycle of the clear still sets the flag.
    if (stall_detect) begin
      nxt_st.lag = 1'b1;
    end
    // Level functions: home, jog and direction blocking while a limit is true.
    nxt_st.home = home_lvl;
    nxt_st.jogp = jogp_lvl;
    nxt_st.jogm = jogm_lvl;
    nxt_st.pblk = plim_lvl;
    nxt_st.mblk = mlim_lvl;
    // Limits request a decelerated stop and record the motion error.
    if (plim_rise) begin
      nxt_st.plim     = 1'b1;
      nxt_st.err_vld  = 1'b1;
      nxt_st.err_code = ERR_LIMP;
    end
    // With both limits at once the minus code is the one left recorded.
    if (mlim_rise) begin
      nxt_st.mlim     = 1'b1;
      nxt_st.err_vld  = 1'b1;
      nxt_st.err_code = ERR_LIMM;
    end
    // Program start always begins at the fixed address.
    if (start_rise) begin
      nxt_st.start      = 1'b1;
      nxt_st.start_addr = START_ADDR;
    end
    // Soft stop outranks pause and ends any pause in progress.
    if (sstop_rise) begin
      nxt_st.sstop  = 1'b1;
      nxt_st.paused = 1'b0;
    end else if (pause_rise) begin
      // Each activation toggles between paused and running.
      nxt_st.paused     = ~st_ff.paused;
      nxt_st.pause_req  = ~st_ff.paused;
      nxt_st.resume_req = st_ff.paused;
    end
    // Reads: data stand only in the cycle after the strobe.
    if (bus_rd) begin
      if (bus_addr < OFF_GPO) begin
        nxt_st.rdata[CFG_TYPE_LSB +: TYPE_W] = st_ff.cfg_type[bus_addr[1:0]];
        nxt_st.rdata[CFG_ACT_BIT]            = st_ff.cfg_act[bus_addr[1:0]];
      end else begin
        case (bus_addr)
          OFF_GPO: nxt_st.rdata[NUM_POINTS-1:0] = st_ff.gpo;
          OFF_INSTAT: begin
            nxt_st.rdata[NUM_POINTS-1:0]                   = true_lvl;
            nxt_st.rdata[INSTAT_RAW_LSB +: NUM_POINTS]     = pin_sync;
          end
          OFF_FLAGS: begin
            nxt_st.rdata[FLG_LAG_BIT]   = st_ff.lag;
            nxt_st.rdata[FLG_PAUSE_BIT] = st_ff.paused;
            nxt_st.rdata[FLG_PBLK_BIT]  = st_ff.pblk;
            nxt_st.rdata[FLG_MBLK_BIT]  = st_ff.mblk;
          end
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register; reset makes every point a general input, true when low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.cfg_type <= {NUM_POINTS{RST_TYPE}};
      st_ff.cfg_act  <= {NUM_POINTS{RST_ACT}};
      st_ff.gpo      <= RST_GPO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output except io_pin_out and io_pin_oe is a field of the state register.
  assign bus_rdata          = st_ff.rdata;
  assign lag_fault_flag     = st_ff.lag;
  assign home_input         = st_ff.home;
  assign plus_limit_stop    = st_ff.plim;
  assign minus_limit_stop   = st_ff.mlim;
  assign plus_move_block    = st_ff.pblk;
  assign minus_move_block   = st_ff.mblk;
  assign motion_error_valid = st_ff.err_vld;
  assign motion_error_code  = st_ff.err_code;
  assign program_start      = st_ff.start;
  assign program_start_addr = st_ff.start_addr;
  assign soft_stop          = st_ff.sstop;
  assign pause_request      = st_ff.pause_req;
  assign resume_request     = st_ff.resume_req;
  assign paused             = st_ff.paused;
  assign jog_plus           = st_ff.jogp;
  assign jog_minus          = st_ff.jogm;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_plus_limit;
    plim_rise && !mlim_rise |=> plus_limit_stop && motion_error_valid && motion_error_code == ERR_LIMP;
  endproperty
  a_plus_limit: assert property (p_plus_limit) else $error("Plus limit not reported.");

  property p_minus_limit;
    mlim_rise |=> minus_limit_stop && motion_error_code == ERR_LIMM && minus_move_block;
  endproperty
  a_minus_limit: assert property (p_minus_limit) else $error("Minus limit not reported.");

  property p_start;
    start_rise |=> program_start && program_start_addr == START_ADDR ##1 !program_start;
  endproperty
  a_start: assert property (p_start) else $error("Program start wrong.");

  property p_soft_stop;
    sstop_rise |=> soft_stop && !paused && !pause_request;
  endproperty
  a_soft_stop: assert property (p_soft_stop) else $error("Soft stop wrong.");

  property p_pause_toggle;
    pause_rise && !sstop_rise |=> (paused != $past(paused)) && (pause_request == paused) && (resume_request == !paused);
  endproperty
  a_pause_toggle: assert property (p_pause_toggle) else $error("Pause toggle wrong.");

  property p_jog;
    ##1 (jog_plus == $past(jogp_lvl)) && (jog_minus == $past(jogm_lvl));
  endproperty
  a_jog: assert property (p_jog) else $error("Jog level wrong.");

  property p_lag_set;
    stall_detect |=> lag_fault_flag;
  endproperty
  a_lag_set: assert property (p_lag_set) else $error("Lag fault not set.");

  property p_lag_hold;
    lag_fault_flag && !(bus_wr && bus_addr == OFF_FLAGS) |=> lag_fault_flag;
  endproperty
  a_lag_hold: assert property (p_lag_hold) else $error("Lag fault dropped.");

  property p_cfg_write;
    bus_wr && bus_addr == OFF_CFG0 ##1 bus_rd && bus_addr == OFF_CFG0 |=>
      bus_rdata[CFG_TYPE_LSB +: TYPE_W] == $past(bus_wdata[CFG_TYPE_LSB +: TYPE_W], 2);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("Setup readback wrong.");

  // The home output follows the ORed home level one cycle later.
  property p_home;
    ##1 home_input == $past(home_lvl);
  endproperty
  a_home: assert property (p_home) else $error("Home level wrong.");

  // Writing 0 to the flag word clears the lag fault when no stall arrives.
  property p_lag_clear;
    bus_wr && bus_addr == OFF_FLAGS && !bus_wdata[FLG_LAG_BIT] && !stall_detect |=> !lag_fault_flag;
  endproperty
  a_lag_clear: assert property (p_lag_clear) else $error("Lag fault not cleared.");

  // Read data are zero except in the cycle after a read strobe.
  property p_rdata_idle;
    !bus_rd |=> bus_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data left standing.");

  // Direction blocks follow the limit levels, so moves stay ignored while a limit is true.
  property p_block;
    ##1 (plus_move_block == $past(plim_lvl)) && (minus_move_block == $past(mlim_lvl));
  endproperty
  a_block: assert property (p_block) else $error("Move block wrong.");

  // A soft stop is a single pulse; a held input must not stop again and again.
  property p_sstop_pulse;
    soft_stop |=> !soft_stop;
  endproperty
  a_sstop_pulse: assert property (p_sstop_pulse) else $error("Soft stop held.");

  c_pause_resume: cover property (paused ##[1:50] resume_request);
  c_plus_limit: cover property (plus_limit_stop);
  c_start: cover property (program_start);
  c_stall: cover property (lag_fault_flag ##1 !lag_fault_flag);
endmodule : mioc_top

/* File: verification/mioc_ext_model.sv */
// External switches and indicator loads that face the four I/O points.
`timescale 1ns/1ps
module mioc_ext_model
  import mioc_pkg::*;
(
  input  wire logic [NUM_POINTS-1:0] sw_closed,
  input  wire logic [NUM_POINTS-1:0] pin_out,
  input  wire logic [NUM_POINTS-1:0] pin_oe,
  output logic      [NUM_POINTS-1:0] pin_level,
  output logic      [NUM_POINTS-1:0] load_on
);
  // A closed switch sinks the line to ground, and an open one lets the pull-up float it high.
  // A driving point wins over the switch, so the bench keeps the switch open while it drives.
  always_comb begin
    for (int i = 0; i < NUM_POINTS; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ~sw_closed[i];
      load_on[i]   = pin_oe[i] & pin_out[i];
    end
  end
endmodule : mioc_ext_model

/* File: verification/tb_top.sv */
// Self-checking bench for the motion I/O point configuration block.
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top import mioc_pkg::*;;
  logic        clk, rst_n, bus_wr, bus_rd;
  logic [3:0]  bus_addr, sw_closed, pin_level, pin_out, pin_oe, load_on;
  logic [31:0] bus_wdata, bus_rdata, rdv;
  logic        mov_f, err_f, vel_f, stall, lag, home, plim, mlim, pblk, mblk;
  logic        mev, pstart, sstop, preq, rreq, paused, jogp, jogm, a;
  logic [1:0]  p;
  logic [7:0]  err_code;
  logic [15:0] start_addr;
  logic [6:0]  pv;
  int          mismatches, cmp_count;
  int          cnt [7] = '{default: 0};
  int          base [7];
  // Expected pulse deltas and levels per input type code 0 to 8.
  logic [6:0]  ep [9] = '{7'h00, 7'h00, 7'h41, 7'h42, 7'h04, 7'h08, 7'h10, 7'h00, 7'h00};
  logic [5:0]  el [9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h00, 6'h00, 6'h08, 6'h10, 6'h20};

  mioc_top u_dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .io_pin_in(pin_level),
    .io_pin_out(pin_out), .io_pin_oe(pin_oe), .motion_active_flag(mov_f),
    .error_indicator_flag(err_f), .velocity_changing_flag(vel_f), .stall_detect(stall),
    .lag_fault_flag(lag), .home_input(home), .plus_limit_stop(plim), .minus_limit_stop(mlim),
    .plus_move_block(pblk), .minus_move_block(mblk), .motion_error_valid(mev),
    .motion_error_code(err_code), .program_start(pstart), .program_start_addr(start_addr),
    .soft_stop(sstop), .pause_request(preq), .resume_request(rreq), .paused(paused),
    .jog_plus(jogp), .jog_minus(jogm));

  mioc_ext_model u_ext (.sw_closed(sw_closed), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level), .load_on(load_on));

  // Counting pulses shows both that a function fired and that it fired only once.
  assign pv = {mev, rreq, preq, sstop, pstart, mlim, plim};
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) cnt[i] <= cnt[i] + int'(pv[i]);
  end

  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // One-cycle write strobe; the strobe drops at the next edge.
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    bus_addr  <= ad;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read edge, so they are taken there.
  task automatic rchk(input logic [3:0] ad, input logic [31:0] e);
    @(posedge clk);
    bus_addr <= ad;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1 rdv = bus_rdata;
    `CHK(rdv, e)
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Watchdog: a hang counts as a mismatch and ends the run.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  // Main sequence: reset state, polarity, input functions, then output functions.
  initial begin
    rst_n = 1'b0; bus_addr = 4'h0; bus_wdata = 32'h0; bus_wr = 1'b0; bus_rd = 1'b0;
    sw_closed = 4'h0; mov_f = 1'b0; err_f = 1'b0; vel_f = 1'b0; stall = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    `CHK(pin_oe, 4'h0)
    for (int i = 0; i < 4; i++) rchk(i[3:0], 32'h0);
    rchk(OFF_GPO, 32'h0);
    rchk(4'h7, 32'h0);
    rchk(OFF_INSTAT, 32'h000000F0);
    sw_closed <= 4'h5;
    wr(OFF_CFG0 + 4'h1, 32'h00000100);
    tick(4);
    rchk(OFF_INSTAT, 32'h000000A7);
    wr(OFF_CFG0 + 4'h1, 32'h0);
    // Each input type 1 to 8: park the switch false, configure, then activate and release.
    for (int t = 1; t <= 8; t++) begin
      p = t[1:0];
      a = t[0];
      sw_closed[p] <= a;
      tick(4);
      wr(OFF_CFG0 + {2'h0, p}, {23'h0, a, 3'h0, t[4:0]});
      tick(6);
      base = cnt;
      @(posedge clk);
      sw_closed[p] <= ~a;
      tick(8);
      for (int i = 0; i < 7; i++) `CHK(cnt[i] - base[i], int'(ep[t][i]))
      `CHK({jogm, jogp, paused, mblk, pblk, home}, el[t])
      if (t == 2 || t == 3) `CHK(err_code, (t == 2) ? ERR_LIMP : ERR_LIMM)
      if (t == 4) `CHK(start_addr, START_ADDR)
      @(posedge clk);
      sw_closed[p] <= a;
      tick(8);
      `CHK({jogm, jogp, paused, mblk, pblk, home}, (t == 6) ? 6'h08 : 6'h00)
      if (t == 6) begin
        @(posedge clk);
        sw_closed[p] <= ~a;
        tick(8);
        `CHK(cnt[5] - base[5], 1)
        `CHK(paused, 1'b0)
        @(posedge clk);
        sw_closed[p] <= a;
      end
      wr(OFF_CFG0 + {2'h0, p}, 32'h0);
    end
    sw_closed <= 4'h0;
    // Output types on point 3 under both polarities with every flag low and high.
    for (int k = 0; k < 2; k++) begin
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        mov_f <= v[0];
        err_f <= v[0];
        vel_f <= v[0];
        stall <= v[0];
        @(posedge clk);
        stall <= 1'b0;
        if (v == 0) begin
          wr(OFF_FLAGS, 32'h1);
          rchk(OFF_FLAGS, {31'h0, k[0]});
          wr(OFF_FLAGS, 32'h0);
          rchk(OFF_FLAGS, 32'h0);
        end else begin
          rchk(OFF_FLAGS, 32'h1);
        end
        wr(OFF_GPO, {28'h0, v[0], 3'h0});
        for (int t = 16; t <= 20; t++) begin
          wr(OFF_CFG0 + 4'h3, {23'h0, k[0], 3'h0, t[4:0]});
          tick(3);
          `CHK(pin_oe, 4'h8)
          `CHK(pin_out[3], v[0] ~^ k[0])
          `CHK(load_on[3], v[0] ~^ k[0])
        end
      end
    end
    wr(OFF_CFG0 + 4'h3, 32'h0);
    tick(3);
    `CHK(pin_oe, 4'h0)
    stop_test();
  end
endmodule : tb_top
